// [ecpwm_top.v]
`timescale 1ns/100ps
`include "ecpwm_defs.vh"
module ecpwm_top #(
	parameter NCH = 8
) (
	input wire mclk_in,
	input wire rst_in,
	input wire [`ECPWM_ADDR_W-1:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [7:0] rdata_out,
	output reg [NCH-1:0] pwm_out
);
	reg [7:0] enable_q;
	reg [7:0] polarity_q;
	reg [7:0] align_q;
	reg [`ECPWM_JOIN_W-1:0] join_q;
	reg [7:0] period_q [0:NCH-1];
	reg [7:0] duty_q [0:NCH-1];
	wire [7:0] cnt8 [0:NCH-1];
	wire [NCH-1:0] act8;
	wire [15:0] cnt16 [0:NCH/2-1];
	wire [NCH/2-1:0] act16;
	reg [NCH-1:0] act_sel;
	reg [7:0] rd_d;
	integer i;
	integer j;
	integer k;

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			enable_q <= `ECPWM_RST_BYTE;
			polarity_q <= `ECPWM_RST_BYTE;
			align_q <= `ECPWM_RST_BYTE;
			join_q <= {`ECPWM_JOIN_W{1'b0}};
			for (i = 0; i < NCH; i = i + 1) begin
				period_q[i] <= `ECPWM_RST_PERIOD;
				duty_q[i] <= `ECPWM_RST_DUTY;
			end
		end else if (wr_in) begin
			case (addr_in)
				`ECPWM_A_ENABLE: enable_q <= wdata_in;
				`ECPWM_A_POLARITY: polarity_q <= wdata_in;
				`ECPWM_A_ALIGN: align_q <= wdata_in;
				`ECPWM_A_JOIN: join_q <= wdata_in[`ECPWM_JOIN_W-1:0];
				default: begin
					for (i = 0; i < NCH; i = i + 1) begin
						if (addr_in == `ECPWM_A_PERIOD0 + i)
							period_q[i] <= wdata_in;
						if (addr_in == `ECPWM_A_DUTY0 + i)
							duty_q[i] <= wdata_in;
					end
				end
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : ch
			ecpwm_counter #(.W(8)) u_c8 (
				.mclk_in(mclk_in),
				.rst_in(rst_in),
				.en_in(enable_q[g] && !join_q[g/2]),
				.center_in(align_q[g]),
				.period_in(period_q[g]),
				.duty_in(duty_q[g]),
				.count_q(cnt8[g]),
				.active_q(act8[g])
			);
		end
		for (g = 0; g < NCH/2; g = g + 1) begin : pr
			// Upper channel's enable, alignment and high byte steer the pair.
			ecpwm_counter #(.W(16)) u_c16 (
				.mclk_in(mclk_in),
				.rst_in(rst_in),
				.en_in(enable_q[2*g+1] && join_q[g]),
				.center_in(align_q[2*g+1]),
				.period_in({period_q[2*g+1], period_q[2*g]}),
				.duty_in({duty_q[2*g+1], duty_q[2*g]}),
				.count_q(cnt16[g]),
				.active_q(act16[g])
			);
		end
	endgenerate

	always @* begin
		for (j = 0; j < NCH; j = j + 1) begin
			if (join_q[j/2])
				act_sel[j] = (j % 2 == 1) ? act16[j/2] : 1'b0;
			else
				act_sel[j] = act8[j];
		end
	end

	always @* begin
		rd_d = 8'h00;
		case (addr_in)
			`ECPWM_A_ENABLE: rd_d = enable_q;
			`ECPWM_A_POLARITY: rd_d = polarity_q;
			`ECPWM_A_ALIGN: rd_d = align_q;
			`ECPWM_A_JOIN: rd_d = {4'h0, join_q};
			`ECPWM_A_OUTPUT: rd_d = pwm_out;
			default: begin
				for (k = 0; k < NCH; k = k + 1) begin
					if (addr_in == `ECPWM_A_PERIOD0 + k)
						rd_d = period_q[k];
					if (addr_in == `ECPWM_A_DUTY0 + k)
						rd_d = duty_q[k];
					if (addr_in == `ECPWM_A_COUNT0 + k)
						rd_d = join_q[k/2] ? ((k % 2 == 1) ? cnt16[k/2][15:8] : cnt16[k/2][7:0]) : cnt8[k];
				end
			end
		endcase
	end

	// Outside reset, which drives every output low, idle channels show their inactive level, so polarity still holds when disabled.
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 8'h00;
			pwm_out <= {NCH{1'b0}};
		end else begin
			rdata_out <= rd_in ? rd_d : 8'h00;
			pwm_out <= act_sel ^ ~polarity_q[NCH-1:0];
		end
	end
endmodule // ecpwm_top

// [ecpwm_defs.vh]
`ifndef ECPWM_DEFS_VH
`define ECPWM_DEFS_VH
// Register addresses (plain port, 8-bit data).
`define ECPWM_ADDR_W 6
`define ECPWM_A_ENABLE 6'h00
`define ECPWM_A_POLARITY 6'h01
`define ECPWM_A_ALIGN 6'h02
`define ECPWM_A_JOIN 6'h03
`define ECPWM_A_OUTPUT 6'h04
`define ECPWM_A_PERIOD0 6'h10
`define ECPWM_A_DUTY0 6'h18
`define ECPWM_A_COUNT0 6'h20
`define ECPWM_RST_PERIOD 8'hff
`define ECPWM_RST_DUTY 8'h00
`define ECPWM_RST_BYTE 8'h00
`define ECPWM_JOIN_W 4
`endif

// [ecpwm_counter.v]
`timescale 1ns/100ps
// One counter and comparator; used for a single 8-bit channel or a joined pair.
module ecpwm_counter #(
	parameter W = 8
) (
	input wire mclk_in,
	input wire rst_in,
	input wire en_in,
	input wire center_in,
	input wire [W-1:0] period_in,
	input wire [W-1:0] duty_in,
	output reg [W-1:0] count_q,
	output reg active_q
);
	reg down_q;
	wire [W-1:0] zero = {W{1'b0}};
	wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};
	// Period is counts per cycle (left) or per half cycle (centre); zero disables.
	wire [W-1:0] last = period_in - one;
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			count_q <= {W{1'b0}};
			down_q <= 1'b0;
			active_q <= 1'b0;
		end else if (!en_in || period_in == zero) begin
			count_q <= {W{1'b0}};
			down_q <= 1'b0;
			active_q <= 1'b0;
		end else begin
			if (!center_in) begin
				count_q <= (count_q >= last) ? zero : count_q + one;
				down_q <= 1'b0;
			end else if (!down_q) begin
				if (count_q >= last)
					down_q <= 1'b1;
				else
					count_q <= count_q + one;
			end else begin
				if (count_q == zero)
					down_q <= 1'b0;
				else
					count_q <= count_q - one;
			end
			// Duty at or above period gives full on, duty zero gives full off.
			active_q <= (count_q < duty_in);
		end
	end
endmodule // ecpwm_counter

// [ecpwm_load.sv]
`timescale 1ns/100ps
// Loads only count high cycles; they never drive back into the block.
module ecpwm_load(
	input wire mclk_in,
	input wire [7:0] pwm_in,
	output int hi_out [8]
);
	initial hi_out = '{default: 0};
	always @(posedge mclk_in) begin
		// Outputs are unknown before the first reset edge; count only solid highs.
		for (int i = 0; i < 8; i++) hi_out[i] <= hi_out[i] + (pwm_in[i] === 1'b1);
	end
endmodule // ecpwm_load

// [ecpwm_sva.sv]
`timescale 1ns/100ps
module ecpwm_sva(
	input wire mclk_in,
	input wire rst_in,
	input wire [5:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [7:0] rdata_out,
	input wire [7:0] pwm_out
);
	logic wq_q;
	logic [5:0] aq_q;
	logic [7:0] dq_q;
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) {wq_q, aq_q, dq_q} <= 15'h0;
		else {wq_q, aq_q, dq_q} <= {wr_in, addr_in, wdata_in};
	end
	// A read right behind a write to the same enable, polarity, align, join, period or duty register must return the written byte; join only its low four bits.
	wire rb = rd_in && wq_q && addr_in == aq_q;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	idle_rdata_a: assert property (!$past(rd_in) |-> rdata_out == 8'h0) else $error("rdata");
	en_rb_a: assert property (rb && aq_q == 6'h0 |=> rdata_out == $past(dq_q)) else $error("en");
	pol_rb_a: assert property (rb && aq_q == 6'h1 |=> rdata_out == $past(dq_q)) else $error("pol");
	aln_rb_a: assert property (rb && aq_q == 6'h2 |=> rdata_out == $past(dq_q)) else $error("aln");
	join_rb_a: assert property (rb && aq_q == 6'h3 |=> ((rdata_out ^ $past(dq_q)) & 8'hf) == 0) else $error("join");
	per_rb_a: assert property (rb && aq_q[5:3] == 3'h2 |=> rdata_out == $past(dq_q)) else $error("per");
	duty_rb_a: assert property (rb && aq_q[5:3] == 3'h3 |=> rdata_out == $past(dq_q)) else $error("duty");
	out_rd_a: assert property (rd_in && addr_in == 6'h4 |=> rdata_out == $past(pwm_out)) else $error("out");
endmodule // ecpwm_sva
bind ecpwm_top ecpwm_sva i_sva(.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .pwm_out);

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
	logic mclk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
	logic [5:0] addr_in = 0;
	logic [7:0] wdata_in = 0, v, pol, aln, jn;
	wire [7:0] rdata_out, pwm_out;
	int hi [8], h0 [8], d [8], bad_count = 0, checks = 0, p, e, w;
	ecpwm_top i_ecpwm_top(.*);
	ecpwm_load i_ecpwm_load(.mclk_in, .pwm_in(pwm_out), .hi_out(hi));
	initial forever #10 mclk_in = ~mclk_in;
	task chk(string n, logic [15:0] s, x);
		checks++;
		if (s !== x) begin
			bad_count++;
			$display("mismatch %s exp %0d got %0d", n, x, s);
		end
	endtask
	task bus(logic wq, logic [5:0] a, logic [7:0] x);
		@(posedge mclk_in);
		wr_in <= wq;
		rd_in <= !wq;
		addr_in <= a;
		wdata_in <= x;
	endtask
	task rd(logic [5:0] a);
		bus(0, a, 0);
		@(posedge mclk_in);
		rd_in <= 0;
		#1 v = rdata_out;
	endtask
	task summarize;
		if (bad_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		v = $urandom(2695);
		repeat (5) @(posedge mclk_in);
		rst_in <= 0;
		for (int a = 0; a < 32; a++) if (a < 4 || a > 15) begin
			e = $urandom % 256;
			bus(1, a, e);
			rd(a);
			chk("reg", v, a == 3 ? e % 16 : e);
		end
		rd(6'h3f);
		chk("unmapped", v, 0);
		repeat (4) begin
			p = 4 + $urandom % 17;
			{pol, aln, jn} = $urandom;
			for (int n = 0; n < 8; n++) begin
				d[n] = $urandom % (p + 2);
				bus(1, 6'h10 + n, jn[n / 2] && n % 2 ? 0 : p);
				bus(1, 6'h18 + n, d[n]);
			end
			bus(1, 6'h1, pol);
			bus(1, 6'h2, aln);
			bus(1, 6'h3, jn);
			bus(1, 6'h0, 8'hff);
			rd(6'h4);
			// Counters may sit above a shrunken period; give them a full wrap.
			repeat (300) @(posedge mclk_in);
			#1 h0 = hi;
			w = 8 * p;
			repeat (w) @(posedge mclk_in);
			#1 for (int n = 0; n < 8; n++) begin
				e = jn[n / 2] && n % 2 ? d[n] * 256 + d[n - 1] : d[n];
				e = w / p * (e < p ? e : p);
				if (jn[n / 2] && n % 2 == 0) chk("lower", (hi[n] - h0[n]) % w, 0);
				else chk("wave", hi[n] - h0[n], pol[n] ? e : w - e);
			end
		end
		summarize;
	end
endmodule // tb_top
